// ### activity_stretch.sv
`timescale 1ns/10ps
`include "link_mgr_map.svh"

module activity_stretch #(
	parameter int unsigned HOLD_CYCLES = `ACT_HOLD_CYCLES
) (
	// Clock and reset.
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Qualified packet event.
	input  wire logic pkt_event,
	// Stretched activity level.
	output logic      active_out
);
	typedef struct packed {
		logic [23:0] cnt;
		logic        act;
	} act_s;

	act_s s_ff;
	act_s nxt_s;

	localparam logic [23:0] LAST = 24'(HOLD_CYCLES - 1);

	// A new packet reloads the hold; the expander samples slowly,
	// so the level must outlast several of its update periods.
	always_comb begin
		nxt_s = s_ff;
		if (pkt_event) begin
			nxt_s.cnt = 24'h000000;
			nxt_s.act = 1'b1;
		end else if (s_ff.act) begin
			if (s_ff.cnt >= LAST) begin
				nxt_s.act = 1'b0;
			end else begin
				nxt_s.cnt = s_ff.cnt + 24'h000001;
			end
		end
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign active_out = s_ff.act;

endmodule : activity_stretch

// ### link_mgr_map.svh
`ifndef LINK_MGR_MAP_SVH
`define LINK_MGR_MAP_SVH

// Register byte offsets on the APB slave.
`define LINK_CONTROL_REG_OFS     8'h00
`define LINK_STATUS_REG_OFS      8'h04
`define LINK_CAPABILITIES_OFS    8'h08
`define SWITCH_CONTROL_REG_OFS   8'h0C
`define SYSTEM_CONTROL_REG_OFS   8'h10
`define DEVICE_CAPABILITIES_OFS  8'h14
`define SLOT_CAPABILITIES_OFS    8'h18
`define POWER_MGMT_CUSTOM_OFS    8'h1C
`define POWER_STATE_REG_OFS      8'h20
`define QUEUE_CONFIG_REG_OFS     8'h24

// Field positions.
`define ASPM_LSB                 0
`define RETRAIN_REQUEST_BIT      2
`define PORT_DISABLE_BIT         3
`define REGISTER_UNLOCK_BIT      0
`define L1_TIMER_LSB             3
`define LINK_UP_STATUS_BIT       7
`define STATE_STATUS_LSB         4
`define CAPTURED_VALUE_LSB       8

// Link width codes.
`define WIDTH_X1                 4'h1
`define WIDTH_X2                 4'h2
`define WIDTH_X4                 4'h4
`define WIDTH_X8                 4'h8

// Reset values and the D3hot power state code.
`define MAX_WIDTH_RST            4'h4
`define FC_CREDITS_RST           8'h40
`define D3HOT_CODE               2'h3

// Entry timer scaling: cycles = (code + 1) shifted left by these.
`define L0S_TIMER_SHIFT          6
`define L1_TIMER_SHIFT           8

// Activity hold time.
`define ACT_HOLD_MS              200
`define CORE_CLK_MHZ             50
`define ACT_HOLD_CYCLES          (`ACT_HOLD_MS * `CORE_CLK_MHZ * 1000)

`endif

// ### link_mgr_pkg.sv
package link_mgr_pkg;

	typedef logic [3:0] width_t;

	typedef enum logic [2:0] {
		LS_DETECT   = 3'h0,
		LS_TRAIN    = 3'h1,
		LS_L0       = 3'h2,
		LS_L0S      = 3'h3,
		LS_L1       = 3'h4,
		LS_RECOVERY = 3'h5,
		LS_L23      = 3'h6,
		LS_DISABLED = 3'h7
	} link_state_e;

	typedef struct packed {
		link_state_e st;
		width_t      neg_width;
		width_t      max_width;
		logic        sw_unlock;
		logic        sys_unlock;
		logic [1:0]  aspm;
		logic        port_off;
		logic [1:0]  pwr_state;
		logic [7:0]  cap_scale;
		logic [1:0]  cap_value;
		logic [9:0]  slot_cap;
		logic [2:0]  l0s_code;
		logic [2:0]  l1_code;
		logic [11:0] l0s_cnt;
		logic [11:0] l1_cnt;
		logic        l1_req;
		logic [7:0]  fc_cfg;
		logic [7:0]  lane_pd;
		logic [7:0]  lane_l1;
		logic        recov;
		logic        flush;
		logic        ur;
		logic        fc_adv;
		logic        spl_send;
		logic        link_up;
		logic        traffic_block;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} mgr_state_s;

endpackage : link_mgr_pkg

// ### link_partner.sv
`timescale 1ns/10ps
module link_partner (
	// Clock and reset.
	input  wire logic                      core_clk,
	input  wire logic                      rst_n,
	// Bench knobs: answer slowly, width offered in training.
	input  wire logic                      slow,
	input  wire link_mgr_pkg::width_t      offer,
	// Switch port side.
	input  wire link_mgr_pkg::link_state_e link_state,
	input  wire logic                      l1_request,
	output logic                           phy_train_done,
	output link_mgr_pkg::width_t           phy_partner_width,
	output logic                           partner_l1_ack
);
	import link_mgr_pkg::*;
	logic [5:0] tcnt_ff;
	logic [5:0] acnt_ff;
	width_t     last_ff;
	logic [5:0] dly;

	// A slow partner takes ten times longer to finish training or ack.
	assign dly = slow ? 6'h1E : 6'h03;
	// Width is only valid with the done pulse; otherwise it is scrambled.
	assign phy_partner_width = phy_train_done ? last_ff : ~last_ff;

	// Training ends a fixed delay after the port starts training.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tcnt_ff        <= 6'h00;
			acnt_ff        <= 6'h00;
			last_ff        <= 4'h0;
			phy_train_done <= 1'b0;
			partner_l1_ack <= 1'b0;
		end else begin
			phy_train_done <= 1'b0;
			partner_l1_ack <= 1'b0;
			if (link_state == LS_TRAIN || link_state == LS_RECOVERY) begin
				tcnt_ff <= (tcnt_ff == 6'h3F) ? tcnt_ff : tcnt_ff + 6'h01;
				if (tcnt_ff == dly) begin
					phy_train_done <= 1'b1;
					last_ff        <= offer;
				end
			end else begin
				tcnt_ff <= 6'h00;
			end
			// The partner grants L1 once per request after the delay.
			if (l1_request) begin
				acnt_ff <= (acnt_ff == 6'h3F) ? acnt_ff : acnt_ff + 6'h01;
				if (acnt_ff == dly) begin
					partner_l1_ack <= 1'b1;
				end
			end else begin
				acnt_ff <= 6'h00;
			end
		end
	end
endmodule : link_partner

// ### switch_port_link_manager.sv
// Behaviour
// R1: Merged trains x8/x4/x2/x1, unmerged x4/x2/x1.
// R2: Report negotiated width in link status.
// R3: Max width writable only when unlocked.
// R4: Max width resets to x4.
// R5: Merged narrow: upper group off, spare lanes L1.
// R6: Unmerged narrow: unused lanes into L1.
// R7: Disabled port powers down all lanes.
// R8: Upstream retrain needs system unlock; go Recovery.
// R9: Downstream retrain always allowed; go Recovery.
// R10: Retraining never resets settings.
// R11: Link down flushes queue, marks Unsupported.
// R12: Config access works while link down.
// R13: Link up advertises configured buffer credits.
// R14: Upstream captures slot power scale, value.
// R15: Downstream sends slot power on triggers.
// R16: ASPM field enables hardware L0s/L1 entry.
// R17: L0s after entry timer of idle.
// R18: Only upstream requests L1; needs partner ack.
// R19: D3hot puts link into L1.
// R20: Turn-off ack enters L2/L3 Ready, no traffic.
// R21: Link-up in L0, L0s, L1, Recovery.
// R22: Activity held 200 ms after packets.
// R23: Entry timers restart when conditions drop.
`timescale 1ns/10ps
`include "link_mgr_map.svh"

module switch_port_link_manager #(
	parameter int unsigned ACT_HOLD = `ACT_HOLD_CYCLES
) (
	// Clock and reset.
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	// APB slave.
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Port straps.
	input  wire logic                  port_upstream,
	input  wire logic                  port_merged,
	// Physical layer events.
	input  wire logic                  phy_partner_present,
	input  wire logic                  phy_train_done,
	input  wire link_mgr_pkg::width_t  phy_partner_width,
	input  wire logic                  phy_link_fail,
	input  wire logic                  phy_exit_idle,
	// Power management conditions.
	input  wire logic                  l0s_idle_cond,
	input  wire logic                  l1_idle_cond,
	input  wire logic                  partner_l1_ack,
	input  wire logic                  turnoff_ack,
	// Slot power message receive.
	input  wire logic                  spl_rx_valid,
	input  wire logic [7:0]            spl_rx_byte0,
	input  wire logic [7:0]            spl_rx_byte1,
	// Packet activity.
	input  wire logic                  tx_pkt_valid,
	input  wire logic                  tx_pkt_vendor,
	input  wire logic                  rx_pkt_valid,
	input  wire logic                  rx_pkt_vendor,
	// Link control outputs.
	output link_mgr_pkg::link_state_e  link_state,
	output link_mgr_pkg::width_t       negotiated_width_field,
	output logic [7:0]                 lane_power_down,
	output logic [7:0]                 lane_low_power,
	output logic                       recovery_start,
	output logic                       l1_request,
	output logic                       queue_flush,
	output logic                       unsupported_mode,
	output logic                       traffic_block,
	output logic                       fc_advertise,
	output logic [7:0]                 fc_credits,
	output logic                       spl_send,
	output logic [9:0]                 spl_payload,
	// Status outputs.
	output logic                       port_link_up_out,
	output logic                       port_activity_out
);
	import link_mgr_pkg::*;

	localparam mgr_state_s S_RST = '{
		st: LS_DETECT, max_width: `MAX_WIDTH_RST, // R4
		fc_cfg: `FC_CREDITS_RST, ur: 1'b1, default: '0};

	mgr_state_s s_ff;
	mgr_state_s nxt_s;
	logic [7:0] lane_pd_c;
	logic [7:0] lane_l1_c;
	logic       wr_fire;
	logic       hit;
	logic       retrain_wr;
	logic       l0s_done;
	logic       l1_done;
	logic [31:0] rd_c;

	// Widest legal width within the capability, partner and port limits.
	function automatic width_t pick_width(input width_t maxw,
		input width_t partner, input logic merged);
		width_t m;
		m = (maxw < partner) ? maxw : partner;
		if (!merged && m > `WIDTH_X4) begin
			m = `WIDTH_X4;
		end
		if (merged && m >= `WIDTH_X8) begin
			pick_width = `WIDTH_X8;
		end else if (m >= `WIDTH_X4) begin
			pick_width = `WIDTH_X4;
		end else if (m >= `WIDTH_X2) begin
			pick_width = `WIDTH_X2;
		end else begin
			pick_width = `WIDTH_X1;
		end
	endfunction : pick_width

	// Entry timer code to cycle count.
	function automatic logic [11:0] entry_cycles(input logic [2:0] code,
		input logic is_l1);
		logic [11:0] base;
		base = {9'h000, code} + 12'h001;
		entry_cycles = is_l1 ? (base << `L1_TIMER_SHIFT)
			: (base << `L0S_TIMER_SHIFT);
	endfunction : entry_cycles

	// States in which the data link layer is up.
	function automatic logic is_up(input link_state_e st);
		is_up = (st == LS_L0) || (st == LS_L0S) || (st == LS_L1)
			|| (st == LS_RECOVERY);
	endfunction : is_up

	// Per-lane power: lanes beyond the trained width idle in L1, the
	// upper group of a narrow merged port is shut off.
	generate
		for (genvar i = 0; i < 8; i++) begin : g_lane
			logic own;
			assign own = port_merged || (i < 4);
			assign lane_pd_c[i] = own && ((s_ff.st == LS_DISABLED) // R7
				|| (is_up(s_ff.st) && port_merged && i >= 4
				&& s_ff.neg_width < `WIDTH_X8)); // R5
			assign lane_l1_c[i] = own && is_up(s_ff.st)
				&& !lane_pd_c[i] && (i >= s_ff.neg_width); // R5 R6
		end
	endgenerate

	// Address decode and read mux; config access ignores link state.
	always_comb begin
		hit = 1'b1;
		rd_c = 32'h00000000;
		case (paddr)
			`LINK_CONTROL_REG_OFS: begin
				rd_c[1:0] = s_ff.aspm;
				rd_c[`PORT_DISABLE_BIT] = s_ff.port_off;
			end
			`LINK_STATUS_REG_OFS: begin
				rd_c[3:0] = s_ff.neg_width; // R2
				rd_c[6:4] = s_ff.st;
				rd_c[`LINK_UP_STATUS_BIT] = s_ff.link_up;
			end
			`LINK_CAPABILITIES_OFS: rd_c[3:0] = s_ff.max_width;
			`SWITCH_CONTROL_REG_OFS: rd_c[0] = s_ff.sw_unlock;
			`SYSTEM_CONTROL_REG_OFS: rd_c[0] = s_ff.sys_unlock;
			`DEVICE_CAPABILITIES_OFS: rd_c[9:0] = {s_ff.cap_value,
				s_ff.cap_scale};
			`SLOT_CAPABILITIES_OFS: rd_c[9:0] = s_ff.slot_cap;
			`POWER_MGMT_CUSTOM_OFS: rd_c[5:0] = {s_ff.l1_code,
				s_ff.l0s_code};
			`POWER_STATE_REG_OFS: rd_c[1:0] = s_ff.pwr_state;
			`QUEUE_CONFIG_REG_OFS: rd_c[7:0] = s_ff.fc_cfg;
			default: hit = 1'b0;
		endcase
	end

	// A write lands at the edge where the master sees pready high.
	assign wr_fire = psel && penable && s_ff.pready && pwrite && hit; // R12
	assign retrain_wr = wr_fire && (paddr == `LINK_CONTROL_REG_OFS)
		&& pwdata[`RETRAIN_REQUEST_BIT]
		&& (!port_upstream || s_ff.sys_unlock); // R8 R9
	assign l0s_done = s_ff.l0s_cnt >= entry_cycles(s_ff.l0s_code, 1'b0)
		- 12'h001;
	assign l1_done = s_ff.l1_cnt >= entry_cycles(s_ff.l1_code, 1'b1)
		- 12'h001;

	// Next state: bus, register writes, link state machine, timers.
	always_comb begin
		nxt_s = s_ff;
		nxt_s.recov = 1'b0;
		nxt_s.flush = 1'b0;
		nxt_s.fc_adv = 1'b0;
		nxt_s.spl_send = 1'b0;
		nxt_s.lane_pd = lane_pd_c;
		nxt_s.lane_l1 = lane_l1_c;
		// One wait state: pready rises in the second access cycle.
		nxt_s.pready = psel && penable && !s_ff.pready;
		nxt_s.pslverr = psel && penable && !s_ff.pready && !hit;
		nxt_s.prdata = (psel && penable && !s_ff.pready) ? rd_c
			: 32'h00000000;
		if (wr_fire) begin
			case (paddr)
				`LINK_CONTROL_REG_OFS: begin
					nxt_s.aspm = pwdata[1:0];
					nxt_s.port_off = pwdata[`PORT_DISABLE_BIT];
				end
				`LINK_CAPABILITIES_OFS: begin
					if (s_ff.sw_unlock) begin
						nxt_s.max_width = pwdata[3:0]; // R3
					end
				end
				`SWITCH_CONTROL_REG_OFS: nxt_s.sw_unlock = pwdata[0];
				`SYSTEM_CONTROL_REG_OFS: nxt_s.sys_unlock = pwdata[0];
				`SLOT_CAPABILITIES_OFS: begin
					nxt_s.slot_cap = pwdata[9:0];
					nxt_s.spl_send = !port_upstream
						&& is_up(s_ff.st); // R15
				end
				`POWER_MGMT_CUSTOM_OFS: begin
					nxt_s.l0s_code = pwdata[2:0];
					nxt_s.l1_code = pwdata[5:3];
				end
				`POWER_STATE_REG_OFS: nxt_s.pwr_state = pwdata[1:0];
				`QUEUE_CONFIG_REG_OFS: nxt_s.fc_cfg = pwdata[7:0];
				default: nxt_s.fc_cfg = s_ff.fc_cfg;
			endcase
		end
		if (spl_rx_valid && port_upstream) begin
			nxt_s.cap_scale = spl_rx_byte0; // R14
			nxt_s.cap_value = spl_rx_byte1[1:0]; // R14
		end
		// Entry timers count only while conditions hold.
		if (s_ff.st == LS_L0 && s_ff.aspm[0] && l0s_idle_cond) begin // R16
			nxt_s.l0s_cnt = (&s_ff.l0s_cnt) ? s_ff.l0s_cnt
				: s_ff.l0s_cnt + 12'h001;
		end else begin
			nxt_s.l0s_cnt = 12'h000; // R23
		end
		if ((s_ff.st == LS_L0 || s_ff.st == LS_L0S) && s_ff.aspm[1]
			&& l1_idle_cond) begin
			nxt_s.l1_cnt = (&s_ff.l1_cnt) ? s_ff.l1_cnt
				: s_ff.l1_cnt + 12'h001;
		end else begin
			nxt_s.l1_cnt = 12'h000; // R23
			nxt_s.l1_req = 1'b0;
		end
		// Retraining touches only the link state, never the settings.
		case (s_ff.st)
			LS_DETECT: begin
				if (phy_partner_present) begin
					nxt_s.st = LS_TRAIN;
				end
			end
			LS_TRAIN, LS_RECOVERY: begin
				if (phy_train_done) begin
					nxt_s.st = LS_L0;
					nxt_s.neg_width = pick_width(s_ff.max_width,
						phy_partner_width, port_merged); // R1
					if (s_ff.st == LS_TRAIN) begin
						nxt_s.fc_adv = 1'b1; // R13
						nxt_s.spl_send = !port_upstream; // R15
					end
				end
			end
			LS_L0: begin
				if (s_ff.pwr_state == `D3HOT_CODE) begin
					nxt_s.st = LS_L1; // R19
				end else if (l1_done && s_ff.aspm[1] && l1_idle_cond
					&& port_upstream) begin
					nxt_s.l1_req = 1'b1; // R18
				end else if (l0s_done && s_ff.aspm[0]
					&& l0s_idle_cond) begin
					nxt_s.st = LS_L0S; // R17
				end
			end
			LS_L0S: begin
				if (s_ff.pwr_state == `D3HOT_CODE) begin
					nxt_s.st = LS_L1; // R19
				end else if (l1_done && s_ff.aspm[1] && l1_idle_cond
					&& port_upstream) begin
					nxt_s.l1_req = 1'b1; // R18
				end else if (!l0s_idle_cond || phy_exit_idle) begin
					nxt_s.st = LS_L0;
				end
			end
			LS_L1: begin
				if (phy_exit_idle) begin
					nxt_s.st = LS_RECOVERY;
				end
			end
			LS_L23: nxt_s.st = LS_L23;
			LS_DISABLED: begin
				if (!s_ff.port_off) begin
					nxt_s.st = LS_DETECT;
				end
			end
			default: nxt_s.st = LS_DETECT;
		endcase
		if (s_ff.l1_req && partner_l1_ack) begin
			nxt_s.st = LS_L1; // R18
			nxt_s.l1_req = 1'b0;
		end
		// Higher priority events override the sequence above.
		if (s_ff.port_off && s_ff.st != LS_DISABLED) begin
			nxt_s.st = LS_DISABLED;
		end else if (phy_link_fail && s_ff.st != LS_DETECT
			&& s_ff.st != LS_DISABLED) begin
			nxt_s.st = LS_DETECT;
		end else if (turnoff_ack && (s_ff.st == LS_L0
			|| s_ff.st == LS_L0S || s_ff.st == LS_L1)) begin
			nxt_s.st = LS_L23; // R20
		end else if (retrain_wr && (s_ff.st == LS_L0
			|| s_ff.st == LS_L0S || s_ff.st == LS_L1)) begin
			nxt_s.st = LS_RECOVERY; // R8 R9 R10
			nxt_s.recov = 1'b1;
		end
		if (nxt_s.st != LS_L0 && nxt_s.st != LS_L0S) begin
			nxt_s.l1_req = 1'b0;
		end
		nxt_s.link_up = is_up(nxt_s.st); // R21
		nxt_s.flush = is_up(s_ff.st) && !is_up(nxt_s.st); // R11
		nxt_s.ur = !is_up(nxt_s.st); // R11
		nxt_s.traffic_block = (nxt_s.st == LS_L23); // R20
		// A disable or link loss in the training cycle must not leak credits.
		if (!is_up(nxt_s.st)) begin
			nxt_s.fc_adv = 1'b0; // R13
			nxt_s.spl_send = 1'b0; // R15
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_ff <= S_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Activity excludes vendor-defined messages.
	activity_stretch #(
		.HOLD_CYCLES (ACT_HOLD)
	) u_act (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.pkt_event  ((tx_pkt_valid && !tx_pkt_vendor)
			|| (rx_pkt_valid && !rx_pkt_vendor)), // R22
		.active_out (port_activity_out)
	);

	// Outputs straight from the state register.
	assign prdata = s_ff.prdata;
	assign pready = s_ff.pready;
	assign pslverr = s_ff.pslverr;
	assign link_state = s_ff.st;
	assign negotiated_width_field = s_ff.neg_width;
	assign lane_power_down = s_ff.lane_pd;
	assign lane_low_power = s_ff.lane_l1;
	assign recovery_start = s_ff.recov;
	assign l1_request = s_ff.l1_req;
	assign queue_flush = s_ff.flush;
	assign unsupported_mode = s_ff.ur;
	assign traffic_block = s_ff.traffic_block;
	assign fc_advertise = s_ff.fc_adv;
	assign fc_credits = s_ff.fc_cfg;
	assign spl_send = s_ff.spl_send;
	assign spl_payload = s_ff.slot_cap;
	assign port_link_up_out = s_ff.link_up;

	// Checks.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_LINK_UP: assert property (port_link_up_out == is_up(link_state)) // R21
		else $error("Link-up output disagrees with link state.");
	AST_MAXW_LOCK: assert property (wr_fire && !s_ff.sw_unlock // R3
		&& paddr == `LINK_CAPABILITIES_OFS |=> $stable(s_ff.max_width))
		else $error("Locked max width changed.");
	AST_UP_RETRAIN: assert property (wr_fire && port_upstream // R8
		&& !s_ff.sys_unlock |=> !recovery_start)
		else $error("Upstream retrain accepted while locked.");
	AST_DS_RETRAIN: assert property (wr_fire && !port_upstream // R9
		&& paddr == `LINK_CONTROL_REG_OFS && pwdata[2]
		&& link_state == LS_L0 && !s_ff.port_off && !phy_link_fail
		&& !turnoff_ack |=> link_state == LS_RECOVERY && recovery_start)
		else $error("Downstream retrain not taken.");
	AST_FLUSH: assert property (is_up(link_state) && phy_link_fail // R11
		&& !s_ff.port_off |=> queue_flush && unsupported_mode
		##1 !queue_flush)
		else $error("Link down did not flush once.");
	AST_L0S_TIME: assert property ($rose(link_state == LS_L0S) // R17
		|-> $past(s_ff.l0s_cnt) >= entry_cycles(s_ff.l0s_code, 1'b0)
		- 12'h002)
		else $error("L0s entered before entry time.");
	AST_SPL_CAP: assert property (spl_rx_valid && port_upstream // R14
		|=> s_ff.cap_scale == $past(spl_rx_byte0)
		&& s_ff.cap_value == $past(spl_rx_byte1[1:0]))
		else $error("Slot power limit not captured.");
	AST_L1_UP_ONLY: assert property (l1_request |-> port_upstream) // R18
		else $error("Downstream port requested L1.");
	AST_DISABLED: assert property (link_state == LS_DISABLED // R7
		|=> lane_power_down == (port_merged ? 8'hFF : 8'h0F))
		else $error("Disabled port lanes not powered down.");
	AST_FC_ADV: assert property (fc_advertise |-> $past(link_state) // R13
		== LS_TRAIN && link_state == LS_L0 && fc_credits == s_ff.fc_cfg)
		else $error("Credits advertised outside link-up.");

	COV_TRAIN: cover property (link_state == LS_TRAIN ##1
		link_state == LS_L0);
	COV_L0S: cover property (link_state == LS_L0 ##1
		link_state == LS_L0S);
	COV_L1: cover property (l1_request ##1 link_state == LS_L1);
	COV_RETRAIN: cover property (recovery_start);

endmodule : switch_port_link_manager

// ### tb.sv
`timescale 1ns/10ps
`include "link_mgr_map.svh"
module tb;
	import link_mgr_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_n    = 1'b0;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [7:0]  paddr    = 8'h00;
	logic [31:0] pwdata   = 32'h0;
	logic [15:0] pay      = 16'h0;
	logic [31:0] prdata, rdat;
	logic        pready, pslverr, rerr, done, ack, l1_req, rec, flush;
	logic        up = 1'b0, pres = 1'b0, fail = 1'b0, slow = 1'b0;
	logic        l0s_c = 1'b0, l1_c = 1'b0, spl_v = 1'b0, vend = 1'b0;
	logic        tx_v = 1'b0, rx_v = 1'b0;
	logic        mrg = 1'b0, toff = 1'b0, blk;
	logic        unsup, spl, fc_adv, link_up, act;
	logic [7:0]  lane_pd, lane_lp, fc_cr;
	logic [9:0]  spl_pl;
	width_t      p_w, n_w;
	link_state_e st;
	int          bad_count = 0, n_compared = 0, cyc_n = 0;
	int          n_rec = 0, n_flush = 0, n_spl = 0, n_fc = 0;

	switch_port_link_manager #(.ACT_HOLD(50)) uut (.core_clk(core_clk),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_upstream(up), .port_merged(mrg),
		.phy_partner_present(pres), .phy_train_done(done),
		.phy_partner_width(p_w), .phy_link_fail(fail),
		.phy_exit_idle(1'b0), .l0s_idle_cond(l0s_c), .l1_idle_cond(l1_c),
		.partner_l1_ack(ack), .turnoff_ack(toff), .spl_rx_valid(spl_v),
		.spl_rx_byte0(pay[7:0]), .spl_rx_byte1(pay[15:8]),
		.tx_pkt_valid(tx_v), .tx_pkt_vendor(vend), .rx_pkt_valid(rx_v),
		.rx_pkt_vendor(vend), .link_state(st), .negotiated_width_field(n_w),
		.lane_power_down(lane_pd), .lane_low_power(lane_lp),
		.recovery_start(rec), .l1_request(l1_req), .queue_flush(flush),
		.unsupported_mode(unsup), .traffic_block(blk),
		.fc_advertise(fc_adv), .fc_credits(fc_cr), .spl_send(spl),
		.spl_payload(spl_pl),
		.port_link_up_out(link_up), .port_activity_out(act));

	link_partner partner (.core_clk(core_clk), .rst_n(rst_n), .slow(slow),
		.offer(4'h4), .link_state(st), .l1_request(l1_req),
		.phy_train_done(done), .phy_partner_width(p_w),
		.partner_l1_ack(ack));

	always #10 core_clk = ~core_clk;

	// Pulses are counted so no one-cycle event is missed between checks.
	always @(posedge core_clk) begin
		n_rec   += (rec === 1'b1);
		n_flush += (flush === 1'b1);
		n_spl   += (spl === 1'b1);
		n_fc    += (fc_adv === 1'b1);
		cyc_n++;
		if (cyc_n == 20000) begin
			bad_count++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	// One APB transfer; the answer is taken at the edge with pready high.
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rdat    = prdata;
		rerr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	task automatic wait_st(input link_state_e s);
		int n;
		n = 0;
		while (st !== s && n < 1000) begin
			@(posedge core_clk);
			n++;
		end
		chk("link_state", s, st);
	endtask : wait_st

	task automatic t_reset;
		apb(0, `LINK_CAPABILITIES_OFS, 0);
		chk("max_width", 4, rdat);
		apb(0, 8'h30, 0);
		chk("unmapped_err", 1, rerr);
		chk("unsupported", 1, unsup);
		$display("test reset finished");
	endtask : t_reset

	task automatic t_linkup;
		pres <= 1'b1;
		wait_st(LS_L0);
		cyc(2);
		chk("width", 4, n_w);
		apb(0, `LINK_STATUS_REG_OFS, 0);
		chk("status_width", 4, rdat[3:0]);
		chk("link_up", 1, link_up);
		chk("fc_count", 1, n_fc);
		chk("fc_credits", 8'h40, fc_cr);
		chk("spl_count", 1, n_spl);
		chk("unsupported", 0, unsup);
		$display("test link up finished");
	endtask : t_linkup

	// Width limit is locked, then changed and applied by a retrain.
	task automatic t_width;
		apb(1, `LINK_CAPABILITIES_OFS, 2);
		apb(0, `LINK_CAPABILITIES_OFS, 0);
		chk("locked_width", 4, rdat);
		apb(1, `SWITCH_CONTROL_REG_OFS, 1);
		apb(1, `LINK_CAPABILITIES_OFS, 2);
		chk("width_before_train", 4, n_w);
		apb(1, `LINK_CONTROL_REG_OFS, 4);
		cyc(2);
		chk("retrain_count", 1, n_rec);
		wait_st(LS_L0);
		cyc(3);
		chk("new_width", 2, n_w);
		chk("lanes_low_power", 4'hC, lane_lp[3:0]);
		apb(0, `LINK_CAPABILITIES_OFS, 0);
		chk("kept_width", 2, rdat);
		apb(1, `SLOT_CAPABILITIES_OFS, 32'h2A5);
		cyc(2);
		chk("spl_count", 2, n_spl);
		chk("spl_payload", 10'h2A5, spl_pl);
		$display("test width finished");
	endtask : t_width

	// The L0s timer restarts when idle drops before it expires.
	task automatic t_l0s;
		apb(1, `POWER_MGMT_CUSTOM_OFS, 0);
		apb(1, `LINK_CONTROL_REG_OFS, 1);
		l0s_c <= 1'b1;
		cyc(40);
		chk("early_state", LS_L0, st);
		l0s_c <= 1'b0;
		cyc(2);
		l0s_c <= 1'b1;
		cyc(50);
		chk("restart_state", LS_L0, st);
		wait_st(LS_L0S);
		l0s_c <= 1'b0;
		cyc(3);
		chk("l0s_exit", LS_L0, st);
		$display("test l0s finished");
	endtask : t_l0s

	task automatic t_act;
		tx_v <= 1'b1;
		vend <= 1'b1;
		cyc(1);
		tx_v <= 1'b0;
		vend <= 1'b0;
		cyc(3);
		chk("vendor_activity", 0, act);
		rx_v <= 1'b1;
		cyc(1);
		rx_v <= 1'b0;
		cyc(47);
		chk("held_activity", 1, act);
		cyc(10);
		chk("expired_activity", 0, act);
		$display("test activity finished");
	endtask : t_act

	task automatic t_down;
		pres <= 1'b0;
		fail <= 1'b1;
		cyc(1);
		fail <= 1'b0;
		cyc(3);
		chk("flush_count", 1, n_flush);
		chk("unsupported", 1, unsup);
		chk("link_up", 0, link_up);
		apb(0, `LINK_CAPABILITIES_OFS, 0);
		chk("down_access", 2, rdat);
		$display("test link down finished");
	endtask : t_down

	// Upstream: power capture, locked retrain, L1 with a slow partner.
	task automatic t_upstream;
		up   <= 1'b1;
		slow <= 1'b1;
		pres <= 1'b1;
		wait_st(LS_L0);
		pay   <= 16'hFE5A;
		spl_v <= 1'b1;
		cyc(1);
		spl_v <= 1'b0;
		cyc(2);
		apb(0, `DEVICE_CAPABILITIES_OFS, 0);
		chk("captured_power", 10'h25A, rdat);
		apb(1, `LINK_CONTROL_REG_OFS, 4);
		cyc(3);
		chk("locked_retrain", 1, n_rec);
		apb(1, `SYSTEM_CONTROL_REG_OFS, 1);
		apb(1, `LINK_CONTROL_REG_OFS, 4);
		cyc(2);
		chk("unlocked_retrain", 2, n_rec);
		wait_st(LS_L0);
		apb(1, `LINK_CONTROL_REG_OFS, 2);
		l1_c <= 1'b1;
		wait_st(LS_L1);
		l1_c <= 1'b0;
		apb(1, `LINK_CONTROL_REG_OFS, 8);
		wait_st(LS_DISABLED);
		cyc(2);
		chk("lanes_off", 4'hF, lane_pd[3:0]);
		$display("test upstream finished");
	endtask : t_upstream

	// Merged narrow port, D3hot entry to L1, then turn-off to L2/L3 Ready.
	task automatic t_power;
		slow <= 1'b0;
		apb(1, `LINK_CONTROL_REG_OFS, 0);
		cyc(1);
		mrg <= 1'b1;
		wait_st(LS_L0);
		cyc(2);
		chk("merged_width", 2, n_w);
		chk("merged_lanes_off", 8'hF0, lane_pd);
		chk("merged_lanes_low", 8'h0C, lane_lp);
		apb(1, `POWER_STATE_REG_OFS, 3);
		wait_st(LS_L1);
		toff <= 1'b1;
		cyc(1);
		toff <= 1'b0;
		cyc(2);
		chk("l23_state", LS_L23, st);
		chk("traffic_block", 1, blk);
		$display("test power finished");
	endtask : t_power

	task automatic end_sim;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	// Reset is held for six cycles before any traffic starts.
	initial begin
		cyc(6);
		rst_n <= 1'b1;
		cyc(1);
		t_reset();
		t_linkup();
		t_width();
		t_l0s();
		t_act();
		t_down();
		t_upstream();
		t_power();
		end_sim();
	end
endmodule : tb
